// [logic/mpd_decode.sv]
// memory partition decode: apb registers, cpu access decode, flash stretch
// assumes the cpu holds a request until ack or berr; ram answers in 1 cycle, flash within 33 ns
//
// Overview of operation
// - each flash access is stretched by the larger of the configured wait-state count and 3
// - user flash base clears to zero on reset
// - zero user base maps all flash to kernel at 0xBD000000 and 0x9D000000
// - kernel flash starts at flash base, ends below user base
// - ram splits into kernel data, kernel program, user data, user program
// - fetch from ram only inside a program region
// - after reset all ram is kernel data, starting at lowest address
// - kernel segments only in kernel mode; low segment in both modes
// - lower 2 GB is user partition, upper 2 GB kernel only
// - user flash at physical 0xBD000000 plus user flash base
// - user ram at physical 0xBF000000 plus user data ram base
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module mpd_decode import mpd_pkg::*; #(
	parameter logic [31:0] FLASH_SIZE = 32'h0008_0000,
	parameter logic [31:0] RAM_SIZE = 32'h0000_8000
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire mpd_req_t cpu_req,
	input wire logic cpu_valid,
	output logic cpu_ack,
	output logic cpu_berr,
	output mpd_mem_t mem_req,
	output logic mem_valid,
	output logic [2:0] flash_wait_states
);
	logic [2:0] ws_ff;
	logic [31:0] user_flash_base_ff;
	logic [31:0] kernel_ram_program_base_ff;
	logic [31:0] user_ram_data_base_ff;
	logic [31:0] user_ram_program_base_ff;
	logic [31:0] prdata_ff, nxt_prdata;
	logic pready_ff, pslverr_ff;
	logic ack_ff, berr_ff, mvalid_ff, busy_ff;
	mpd_mem_t mem_ff;
	logic [2:0] cnt_ff, nxt_cnt;
	logic nxt_busy;

	// apb decode
	wire apb_acc = psel & penable;
	wire apb_wr = apb_acc & pwrite & ~pslverr_ff;
	wire hit_cc = paddr == REG_CACHE_CTRL;
	wire hit_ufb = paddr == REG_USER_FLASH_BASE;
	wire hit_krp = paddr == REG_KERNEL_RAM_PGM_BASE;
	wire hit_urd = paddr == REG_USER_RAM_DATA_BASE;
	wire hit_urp = paddr == REG_USER_RAM_PGM_BASE;
	wire hit_fs = paddr == REG_FLASH_SIZE;
	wire hit_rs = paddr == REG_RAM_SIZE;
	wire hit_st = paddr == REG_STATUS;
	wire hit_any = hit_cc | hit_ufb | hit_krp | hit_urd | hit_urp |
		hit_fs | hit_rs | hit_st;
	// read-only size registers refuse writes
	wire bad = ~hit_any | (pwrite & (hit_fs | hit_rs | hit_st));

	always_comb begin
		nxt_prdata = 32'h0000_0000;
		case (paddr)
			REG_CACHE_CTRL: begin
				nxt_prdata[WS_LSB +: WS_W] = ws_ff;
			end
			REG_USER_FLASH_BASE: nxt_prdata = user_flash_base_ff;
			REG_KERNEL_RAM_PGM_BASE:
				nxt_prdata = kernel_ram_program_base_ff;
			REG_USER_RAM_DATA_BASE: nxt_prdata = user_ram_data_base_ff;
			REG_USER_RAM_PGM_BASE:
				nxt_prdata = user_ram_program_base_ff;
			REG_FLASH_SIZE: nxt_prdata = FLASH_SIZE;
			REG_RAM_SIZE: nxt_prdata = RAM_SIZE;
			// status: wait count running, access busy, user flash present
			REG_STATUS: nxt_prdata = {29'h0000_0000, cnt_ff != 3'h0,
				busy_ff, user_flash_base_ff != BASE_RST};
			default: nxt_prdata = 32'h0000_0000;
		endcase
	end

	// one wait state on apb: answer on the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end else begin
			pready_ff <= apb_acc & ~pready_ff;
			// error rides with pready so the pin is a plain flop
			pslverr_ff <= apb_acc & ~pready_ff & bad;
			if (apb_acc & ~pready_ff & ~pwrite) prdata_ff <= nxt_prdata;
		end
	end

	// write takes effect on the completing edge
	// size and status registers have no write path
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ws_ff <= WS_RST;
			user_flash_base_ff <= BASE_RST;
			kernel_ram_program_base_ff <= BASE_RST;
			user_ram_data_base_ff <= BASE_RST;
			user_ram_program_base_ff <= BASE_RST;
		end else if (apb_wr & pready_ff) begin
			if (hit_cc) ws_ff <= pwdata[WS_LSB +: WS_W];
			if (hit_ufb) user_flash_base_ff <= pwdata;
			if (hit_krp) kernel_ram_program_base_ff <= pwdata;
			if (hit_urd) user_ram_data_base_ff <= pwdata;
			if (hit_urp) user_ram_program_base_ff <= pwdata;
		end
	end

	// effective ram and flash bounds; a zero base means the region does not exist
	wire [31:0] urd_eff = (user_ram_data_base_ff == BASE_RST) ?
		RAM_SIZE : user_ram_data_base_ff;
	wire [31:0] urp_eff = (user_ram_program_base_ff == BASE_RST) ?
		RAM_SIZE : user_ram_program_base_ff;
	wire [31:0] kend_eff = (user_ram_data_base_ff != BASE_RST) ? urd_eff :
		urp_eff;
	wire [31:0] krp_eff = (kernel_ram_program_base_ff == BASE_RST) ?
		kend_eff : kernel_ram_program_base_ff;
	wire [31:0] ufb_eff = (user_flash_base_ff == BASE_RST) ?
		FLASH_SIZE : user_flash_base_ff;

	// combinational address decode against live bases
	wire [31:0] va = cpu_req.addr;
	wire is_kernel_half = va[31];
	wire [31:0] va_k = {3'b000, va[28:0]};
	wire in_kflash_seg = (va[31:24] == KSEG1_FLASH[31:24]) |
		(va[31:24] == KSEG0_FLASH[31:24]);
	wire [31:0] kf_off = {8'h00, va[23:0]};
	wire in_kram_seg = (va[31:29] == KSEG0_RAM[31:29] |
		va[31:29] == KSEG1_RAM[31:29]) & (va_k < kend_eff);
	wire kflash_ok = in_kflash_seg & (kf_off < ufb_eff);
	wire kram_data = in_kram_seg & (va_k < krp_eff);
	wire kram_pgm = in_kram_seg & (va_k >= krp_eff);
	wire [31:0] u_off = {8'h00, va[23:0]};
	wire uflash_ok = (va[31:24] == USEG_FLASH[31:24]) &
		(u_off >= ufb_eff) & (u_off < FLASH_SIZE);
	wire in_uram = (va[31:24] == USEG_RAM[31:24]) &
		(u_off >= urd_eff) & (u_off < RAM_SIZE);
	wire uram_data = in_uram & (u_off < urp_eff);
	wire uram_pgm = in_uram & (u_off >= urp_eff);
	// fetch from ram data regions is never allowed
	wire ram_fetch_bad = cpu_req.fetch & (kram_data | uram_data);
	wire kseg_ok = ~cpu_req.user_mode & (kflash_ok | kram_data | kram_pgm);
	wire useg_ok = uflash_ok | uram_data | uram_pgm;
	wire allow = (is_kernel_half ? kseg_ok : useg_ok) & ~ram_fetch_bad;
	wire to_flash = is_kernel_half ? kflash_ok : uflash_ok;

	mpd_mem_t nxt_mem;
	// user half maps into the high physical window
	always_comb begin
		nxt_mem.tgt = to_flash ? TGT_FLASH : TGT_RAM;
		if (to_flash) begin
			nxt_mem.offset = is_kernel_half ? PHYS_KERN_FLASH + kf_off :
				PHYS_USER_FLASH + u_off;
		end else begin
			nxt_mem.offset = is_kernel_half ? va_k : PHYS_USER_RAM + u_off;
		end
	end

	// a held request must not be taken again while its answer is out
	wire start = cpu_valid & ~busy_ff & ~ack_ff & ~berr_ff;
	// flash waits at least the access time even with zero wait states
	wire [2:0] flash_cnt = (ws_ff < 3'(FLASH_MIN_CYC - 1)) ?
		3'(FLASH_MIN_CYC - 1) : ws_ff;
	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_busy = busy_ff;
		if (start & allow) begin
			nxt_busy = 1'b1;
			nxt_cnt = to_flash ? flash_cnt : 3'h0;
		end else if (busy_ff) begin
			if (cnt_ff == 3'h0) begin
				nxt_busy = 1'b0;
			end else begin
				nxt_cnt = cnt_ff - 3'h1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_ff <= 1'b0;
			cnt_ff <= 3'h0;
			ack_ff <= 1'b0;
			berr_ff <= 1'b0;
			mvalid_ff <= 1'b0;
			mem_ff <= '0;
		end else begin
			busy_ff <= nxt_busy;
			cnt_ff <= nxt_cnt;
			// ack one cycle after the count has run out
			ack_ff <= busy_ff & (cnt_ff == 3'h0);
			berr_ff <= start & ~allow;
			mvalid_ff <= start & allow;
			if (start & allow) mem_ff <= nxt_mem;
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign cpu_ack = ack_ff;
	assign cpu_berr = berr_ff;
	assign mem_req = mem_ff;
	assign mem_valid = mvalid_ff;
	assign flash_wait_states = ws_ff;
endmodule : mpd_decode
`default_nettype wire

// [pkg/mpd_pkg.sv]
// memory partition decode: constants, register map, carrier types
// assumes a 32-bit virtual address space split into user and kernel halves
package mpd_pkg;
	// apb register byte offsets
	localparam logic [7:0] REG_CACHE_CTRL = 8'h00;
	localparam logic [7:0] REG_USER_FLASH_BASE = 8'h04;
	localparam logic [7:0] REG_KERNEL_RAM_PGM_BASE = 8'h08;
	localparam logic [7:0] REG_USER_RAM_DATA_BASE = 8'h0c;
	localparam logic [7:0] REG_USER_RAM_PGM_BASE = 8'h10;
	localparam logic [7:0] REG_FLASH_SIZE = 8'h14;
	localparam logic [7:0] REG_RAM_SIZE = 8'h18;
	localparam logic [7:0] REG_STATUS = 8'h1c;
	// field positions
	localparam int WS_LSB = 0;
	localparam int WS_W = 3;
	// reset values
	localparam logic [2:0] WS_RST = 3'h7;
	localparam logic [31:0] BASE_RST = 32'h0000_0000;
	// address map
	localparam logic [31:0] KSEG1_FLASH = 32'hbd00_0000;
	localparam logic [31:0] KSEG0_FLASH = 32'h9d00_0000;
	localparam logic [31:0] KSEG0_RAM = 32'h8000_0000;
	localparam logic [31:0] KSEG1_RAM = 32'ha000_0000;
	localparam logic [31:0] USEG_FLASH = 32'h7d00_0000;
	localparam logic [31:0] USEG_RAM = 32'h7f00_0000;
	localparam logic [31:0] PHYS_USER_FLASH = 32'hbd00_0000;
	localparam logic [31:0] PHYS_USER_RAM = 32'hbf00_0000;
	localparam logic [31:0] PHYS_KERN_FLASH = 32'h1d00_0000;
	// timing
	localparam int FLASH_ACCESS_NS = 33;
	localparam int CLK_PERIOD_NS = 10;
	localparam int FLASH_MIN_CYC =
		(FLASH_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		TGT_NONE = 2'b00,
		TGT_FLASH = 2'b01,
		TGT_RAM = 2'b10
	} mpd_tgt_t;

	typedef struct packed {
		logic [31:0] addr;
		logic write;
		logic fetch;
		logic user_mode;
	} mpd_req_t;

	typedef struct packed {
		mpd_tgt_t tgt;
		logic [31:0] offset;
	} mpd_mem_t;
endpackage : mpd_pkg

// [test/memory_partition_decode_bench.sv]
// bench: apb set-up of partitions, cpu accesses, wait-state timing
// assumes mpd_decode with default sizes and the cpu model
`timescale 1ns/1ns
`default_nettype none
module memory_partition_decode_bench import mpd_pkg::*;;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready, pslverr, cpu_valid, cpu_ack, cpu_berr, mem_valid;
	logic [2:0] flash_wait_states;
	mpd_req_t cpu_req;
	mpd_mem_t mem_req;
	int n_mismatch = 0;
	int comparisons = 0;
	int cyc = 0;
	mpd_decode uut (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.cpu_req(cpu_req),
		.cpu_valid(cpu_valid),
		.cpu_ack(cpu_ack),
		.cpu_berr(cpu_berr),
		.mem_req(mem_req),
		.mem_valid(mem_valid),
		.flash_wait_states(flash_wait_states)
	);
	mpd_cpu_model u_cpu (
		.pclk(pclk),
		.cpu_ack(cpu_ack),
		.cpu_berr(cpu_berr),
		.cpu_req(cpu_req),
		.cpu_valid(cpu_valid)
	);
	always #5 pclk = ~pclk;
	task end_of_test;
		if (n_mismatch == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : end_of_test
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			end_of_test();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		comparisons++;
		if (g !== x) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// only the bench timeout ends a wait for pready
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
		@(posedge pclk);
	endtask : apb
	task automatic cpu(input logic [31:0] a, input logic [2:0] f, input logic x);
		logic ok;
		int n;
		u_cpu.access(mpd_req_t'({a, f}), ok, n);
		chk({31'h0, ok}, {31'h0, x});
		if (!x) chk(32'(n), 32'h2);
		@(posedge pclk);
	endtask : cpu
	task automatic t_reset;
		logic [31:0] q;
		logic e;
		apb(1'b0, REG_CACHE_CTRL, 32'h0, q, e);
		chk(q & 32'h0000_0007, 32'h0000_0007);
		for (int i = 1; i < 5; i++) begin
			apb(1'b0, 8'(4 * i), 32'h0, q, e);
			chk(q, BASE_RST);
		end
		apb(1'b1, REG_FLASH_SIZE, 32'h0, q, e);
		chk({31'h0, e}, 32'h1);
		apb(1'b0, REG_FLASH_SIZE, 32'h0, q, e);
		chk(q, 32'h0008_0000);
		apb(1'b0, 8'h20, 32'h0, q, e);
		chk({31'h0, e}, 32'h1);
	endtask : t_reset
	task automatic t_default;
		cpu(32'hbd07_fffc, 3'h0, 1'b1);
		cpu(32'h9d00_0000, 3'h2, 1'b1);
		cpu(32'h7d07_fffc, 3'h1, 1'b0);
		cpu(32'hbd00_0000, 3'h1, 1'b0);
		cpu(32'h8000_0010, 3'h2, 1'b0);
		cpu(32'ha000_7ffc, 3'h4, 1'b1);
		cpu(32'h8000_8000, 3'h0, 1'b0);
	endtask : t_default
	task automatic t_wait;
		logic [31:0] q;
		logic e, ok;
		int n0, n3, n7;
		apb(1'b1, REG_CACHE_CTRL, 32'h0, q, e);
		u_cpu.access(mpd_req_t'({32'hbd00_0000, 3'h0}), ok, n0);
		@(posedge pclk);
		apb(1'b1, REG_CACHE_CTRL, 32'(FLASH_MIN_CYC - 1), q, e);
		u_cpu.access(mpd_req_t'({32'hbd00_0000, 3'h0}), ok, n3);
		@(posedge pclk);
		apb(1'b1, REG_CACHE_CTRL, 32'h7, q, e);
		u_cpu.access(mpd_req_t'({32'hbd00_0000, 3'h0}), ok, n7);
		@(posedge pclk);
		chk(32'(n0), 32'(FLASH_MIN_CYC + 2));
		chk(32'(n3), 32'(FLASH_MIN_CYC + 2));
		chk(32'(n7 - n0), 32'h4);
	endtask : t_wait
	task automatic t_partition;
		logic [31:0] q;
		logic e;
		apb(1'b1, REG_USER_FLASH_BASE, 32'h0007_b000, q, e);
		cpu(32'h7d07_b000, 3'h3, 1'b1);
		cpu(32'h7d07_affc, 3'h1, 1'b0);
		cpu(32'hbd07_affc, 3'h0, 1'b1);
		cpu(32'hbd07_b000, 3'h0, 1'b0);
		apb(1'b1, REG_KERNEL_RAM_PGM_BASE, 32'h0000_2000, q, e);
		apb(1'b1, REG_USER_RAM_DATA_BASE, 32'h0000_4000, q, e);
		apb(1'b1, REG_USER_RAM_PGM_BASE, 32'h0000_6000, q, e);
		cpu(32'h8000_2000, 3'h2, 1'b1);
		cpu(32'h8000_1ffc, 3'h2, 1'b0);
		cpu(32'h8000_4000, 3'h0, 1'b0);
		cpu(32'h7f00_4000, 3'h5, 1'b1);
		cpu(32'h7f00_4000, 3'h3, 1'b0);
		cpu(32'h7f00_6000, 3'h3, 1'b1);
		apb(1'b0, REG_USER_FLASH_BASE, 32'h0, q, e);
		chk(q, 32'h0007_b000);
	endtask : t_partition
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_default();
		t_wait();
		t_partition();
		end_of_test();
	end
endmodule : memory_partition_decode_bench
`default_nettype wire

// [test/mpd_cpu_model.sv]
// cpu core model: issues one held access and waits for ack or berr
// assumes calls start just after a pclk edge, with an idle cycle between
`timescale 1ns/1ns
`default_nettype none
module mpd_cpu_model import mpd_pkg::*; (
	input wire logic pclk,
	input wire logic cpu_ack,
	input wire logic cpu_berr,
	output mpd_req_t cpu_req,
	output logic cpu_valid
);
	initial cpu_req = '0;
	initial cpu_valid = 1'b0;
	task automatic access(input mpd_req_t r, output logic ok, output int n);
		n = 0;
		cpu_req <= r;
		cpu_valid <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (cpu_ack !== 1'b1 && cpu_berr !== 1'b1);
		ok = cpu_ack;
		cpu_valid <= 1'b0;
		// released bus shows no stale address
		cpu_req <= mpd_req_t'(~r);
	endtask : access
endmodule : mpd_cpu_model
`default_nettype wire

// [test/mpd_decode_props.sv]
// checker: decode timing and mapping relations at the decode ports
// assumes bind to mpd_decode, one pclk domain
`timescale 1ns/1ns
`default_nettype none
module mpd_decode_props import mpd_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire mpd_req_t cpu_req,
	input wire logic cpu_valid,
	input wire logic cpu_ack,
	input wire logic cpu_berr,
	input wire mpd_mem_t mem_req,
	input wire logic mem_valid,
	input wire logic [2:0] flash_wait_states
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	wire ws_wr = psel && penable && pready && pwrite &&
		paddr == REG_CACHE_CTRL;
	wire [2:0] wd = pwdata[2:0];
	wire up = cpu_valid && cpu_req.user_mode && cpu_req.addr[31];
	a_ram_ack: assert property (
		mem_valid && mem_req.tgt == TGT_RAM |=> cpu_ack)
		else $error("ram access not acked next cycle");
	a_flash_floor: assert property (
		mem_valid && mem_req.tgt == TGT_FLASH |=> !cpu_ack [*3])
		else $error("flash ack under 33 ns");
	a_flash_ws7: assert property (
		mem_valid && mem_req.tgt == TGT_FLASH && flash_wait_states == 3'h7
		|-> ##8 cpu_ack) else $error("ws7 ack late");
	a_user_phys: assert property (
		mem_valid && cpu_req.user_mode
		|-> mem_req.offset == cpu_req.addr + 32'h4000_0000)
		else $error("user phys");
	a_kern_phys: assert property (
		mem_valid && cpu_req.addr[31]
		|-> mem_req.offset == {3'h0, cpu_req.addr[28:0]})
		else $error("kern phys");
	a_user_upper: assert property (up |-> ##[0:4] cpu_berr)
		else $error("user upper access not refused");
	a_upper_nomem: assert property (up |-> !mem_valid)
		else $error("user upper access reached memory");
	a_ws_write: assert property (ws_wr |=> flash_wait_states == $past(wd))
		else $error("wait states not written");
endmodule : mpd_decode_props
bind mpd_decode mpd_decode_props u_props (
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.pready(pready),
	.cpu_req(cpu_req),
	.cpu_valid(cpu_valid),
	.cpu_ack(cpu_ack),
	.cpu_berr(cpu_berr),
	.mem_req(mem_req),
	.mem_valid(mem_valid),
	.flash_wait_states(flash_wait_states)
);
`default_nettype wire
